/* File: src/phj_consts.svh */
// constants for the port h/j pin override block: register offsets,
// field positions, reset values and bus timing.
// assumes inclusion by bare name from the package and the top module.
`ifndef PHJ_CONSTS_SVH
`define PHJ_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define PHJ_OFS_MASK_H   4'h0
`define PHJ_OFS_MASK_J   4'h4
`define PHJ_OFS_CTRL     4'h8
`define PHJ_OFS_STATUS   4'hc

// ----------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------
`define PHJ_PORT_W       8
`define PHJ_J_ALT_W      7
`define PHJ_CTRL_GEN_BIT 0
`define PHJ_STAT_H_LSB   0
`define PHJ_STAT_J_LSB   8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PHJ_RST_MASK_H   8'h00
`define PHJ_RST_MASK_J   7'h00
`define PHJ_RST_GEN      1'b0
`define PHJ_RST_OVR      8'h00

// ----------------------------------------------------------------------
// timing: synchroniser depth and bus answer latency in cycles
// ----------------------------------------------------------------------
`define PHJ_SYNC_STAGES  2
`define PHJ_ACK_CYCLES   1

`endif

/* File: src/phj_pkg.sv */
// types shared by the port h/j pin override block.
// assumes the constants header is on the include path.
package phj_pkg;
  `include "phj_consts.svh"

  // ----------------------------------------------------------------------
  // data types
  // ----------------------------------------------------------------------
  typedef logic [`PHJ_PORT_W-1:0]  phj_port_t;   // one full 8-bit port
  typedef logic [`PHJ_J_ALT_W-1:0] phj_jalt_t;   // port j bits 6:0
  typedef logic [31:0]             phj_word_t;   // bus data word
  typedef logic [3:0]              phj_addr_t;   // byte address in block

  // register selected by a bus address, one-hot
  typedef enum logic [4:0] {
    PHJ_SEL_NONE   = 5'h01,
    PHJ_SEL_MASK_H = 5'h02,
    PHJ_SEL_MASK_J = 5'h04,
    PHJ_SEL_CTRL   = 5'h08,
    PHJ_SEL_STATUS = 5'h10
  } phj_sel_t;
endpackage

/* File: src/phj_sync.sv */
// two-flop synchroniser bank for asynchronous pin levels.
// assumes levels, not pulses shorter than a clock period.
`timescale 1ns/10ps
module phj_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // ----------------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] meta_reg;   // first stage, read only by the second
  logic [WIDTH-1:0] meta_next;  // next value of the first stage
  logic [WIDTH-1:0] hold_reg;   // second stage, safe to use
  logic [WIDTH-1:0] hold_next;  // next value of the second stage

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      // next values: shift the pin through the chain
      always_comb begin
        meta_next[gi] = async_in[gi];
        hold_next[gi] = meta_reg[gi];
      end

      // register only; constants under reset
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_reg[gi] <= 1'b0;
          hold_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= meta_next[gi];
          hold_reg[gi] <= hold_next[gi];
        end
      end
    end
  endgenerate

  assign sync_out = hold_reg;
endmodule

/* File: src/phj_pin_override.sv */
// override generator for the alternate function of ports h and j.
// the only alternate function on these pins is pin-change sensing.
// assumes a classic wishbone master on ref_clk and raw pin levels that
// are asynchronous to ref_clk; the generic pin logic sits outside.
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "phj_consts.svh"
module phj_pin_override (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire phj_pkg::phj_addr_t wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire phj_pkg::phj_word_t wb_dat_i,
  output phj_pkg::phj_word_t     wb_dat_o,
  output logic                   wb_ack_o,
  // raw pin levels
  input  wire phj_pkg::phj_port_t pin_h_in,
  input  wire phj_pkg::phj_jalt_t pin_j_in,
  // port h override signals
  output phj_pkg::phj_port_t     h_pullup_override_en,
  output phj_pkg::phj_port_t     h_pullup_override_val,
  output phj_pkg::phj_port_t     h_direction_override_en,
  output phj_pkg::phj_port_t     h_direction_override_val,
  output phj_pkg::phj_port_t     h_outvalue_override_en,
  output phj_pkg::phj_port_t     h_outvalue_override_val,
  output phj_pkg::phj_port_t     h_toggle_override_en,
  output phj_pkg::phj_port_t     h_input_enable_override_en,
  output phj_pkg::phj_port_t     h_input_enable_override_val,
  // port j override signals
  output phj_pkg::phj_port_t     j_pullup_override_en,
  output phj_pkg::phj_port_t     j_pullup_override_val,
  output phj_pkg::phj_port_t     j_direction_override_en,
  output phj_pkg::phj_port_t     j_direction_override_val,
  output phj_pkg::phj_port_t     j_outvalue_override_en,
  output phj_pkg::phj_port_t     j_outvalue_override_val,
  output phj_pkg::phj_port_t     j_toggle_override_en,
  output phj_pkg::phj_port_t     j_input_enable_override_en,
  output phj_pkg::phj_port_t     j_input_enable_override_val,
  // digital inputs routed to the pin-change sources
  output phj_pkg::phj_port_t     change_source_h,
  output phj_pkg::phj_jalt_t     change_source_j
);
  import phj_pkg::*;

  // ----------------------------------------------------------------------
  // address decode, shared by the write and read paths
  // ----------------------------------------------------------------------
  function automatic phj_sel_t reg_select(input phj_addr_t adr);
    phj_sel_t sel;
    begin
      sel = PHJ_SEL_NONE;
      case (adr)
        `PHJ_OFS_MASK_H: sel = PHJ_SEL_MASK_H;
        `PHJ_OFS_MASK_J: sel = PHJ_SEL_MASK_J;
        `PHJ_OFS_CTRL:   sel = PHJ_SEL_CTRL;
        `PHJ_OFS_STATUS: sel = PHJ_SEL_STATUS;
        default:         sel = PHJ_SEL_NONE;
      endcase
      reg_select = sel;
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  phj_port_t pin_h_sync;   // port h levels in the ref_clk domain
  phj_jalt_t pin_j_sync;   // port j bits 6:0 in the ref_clk domain

  // one bank for both ports keeps the crossing in a single place
  phj_sync #(
    .WIDTH (`PHJ_PORT_W + `PHJ_J_ALT_W)
  ) i_phj_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({pin_j_in, pin_h_in}),
    .sync_out ({pin_j_sync, pin_h_sync})
  );

  // ----------------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------------
  phj_port_t mask_h_reg;    // change mask, port h
  phj_port_t mask_h_next;
  phj_jalt_t mask_j_reg;    // change mask, port j bits 6:0
  phj_jalt_t mask_j_next;
  logic      gen_reg;       // change group enable
  logic      gen_next;
  logic      ack_reg;       // wishbone acknowledge
  logic      ack_next;
  phj_word_t rdat_reg;      // read data, captured with the ack
  phj_word_t rdat_next;
  logic      bus_req;       // a request is present and not yet answered
  phj_sel_t  bus_sel;       // decoded target of the request

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_sel = reg_select(wb_adr_i);

  // next bus state: answer every request one cycle after it arrives,
  // drop ack the cycle after; unmapped offsets read zero, writes ignored
  always_comb begin
    mask_h_next = mask_h_reg;
    mask_j_next = mask_j_reg;
    gen_next    = gen_reg;
    ack_next    = bus_req;
    rdat_next   = rdat_reg;
    if (bus_req && wb_we_i && wb_sel_i[0]) begin
      // only byte lane 0 holds writable bits
      case (bus_sel)
        PHJ_SEL_MASK_H: mask_h_next = wb_dat_i[`PHJ_PORT_W-1:0];
        PHJ_SEL_MASK_J: mask_j_next = wb_dat_i[`PHJ_J_ALT_W-1:0];
        PHJ_SEL_CTRL:   gen_next    = wb_dat_i[`PHJ_CTRL_GEN_BIT];
        default:        gen_next    = gen_reg; // status and holes
      endcase
    end
    if (bus_req && !wb_we_i) begin
      rdat_next = 32'h0000_0000;
      case (bus_sel)
        PHJ_SEL_MASK_H: rdat_next[`PHJ_PORT_W-1:0]  = mask_h_reg;
        PHJ_SEL_MASK_J: rdat_next[`PHJ_J_ALT_W-1:0] = mask_j_reg;
        PHJ_SEL_CTRL:   rdat_next[`PHJ_CTRL_GEN_BIT] = gen_reg;
        PHJ_SEL_STATUS: begin
          // live synchronised pin levels, bit 7 of port j reads zero
          rdat_next[`PHJ_STAT_H_LSB +: `PHJ_PORT_W]  = pin_h_sync;
          rdat_next[`PHJ_STAT_J_LSB +: `PHJ_J_ALT_W] = pin_j_sync;
        end
        default:        rdat_next = 32'h0000_0000;
      endcase
    end
  end

  // register the bus state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_h_reg <= `PHJ_RST_MASK_H;
      mask_j_reg <= `PHJ_RST_MASK_J;
      gen_reg    <= `PHJ_RST_GEN;
      ack_reg    <= 1'b0;
      rdat_reg   <= 32'h0000_0000;
    end else begin
      mask_h_reg <= mask_h_next;
      mask_j_reg <= mask_j_next;
      gen_reg    <= gen_next;
      ack_reg    <= ack_next;
      rdat_reg   <= rdat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ----------------------------------------------------------------------
  // override outputs
  // ----------------------------------------------------------------------
  phj_port_t h_die_en_reg;   // input-enable override enable, port h
  phj_port_t h_die_en_next;
  phj_port_t j_die_en_reg;   // input-enable override enable, port j
  phj_port_t j_die_en_next;
  phj_port_t src_h_reg;      // routed digital input, port h
  phj_port_t src_h_next;
  phj_jalt_t src_j_reg;      // routed digital input, port j
  phj_jalt_t src_j_next;

  // next override state; the input-enable override is taken on each
  // masked pin while sensing is armed and forces the digital input
  // enable to 0, at the price of one cycle of lag after a write
  always_comb begin
    h_die_en_next = mask_h_reg & {`PHJ_PORT_W{gen_reg}};
    // bit 7 of port j has no alternate function and stays zero
    j_die_en_next = {1'b0,
                     mask_j_reg & {`PHJ_J_ALT_W{gen_reg}}};
    src_h_next    = pin_h_sync;  // bit n drives source 16+n
    src_j_next    = pin_j_sync;  // bit n drives source 24+n
  end

  // register the override state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      h_die_en_reg <= `PHJ_RST_OVR;
      j_die_en_reg <= `PHJ_RST_OVR;
      src_h_reg    <= `PHJ_RST_OVR;
      src_j_reg    <= `PHJ_RST_MASK_J;
    end else begin
      h_die_en_reg <= h_die_en_next;
      j_die_en_reg <= j_die_en_next;
      src_h_reg    <= src_h_next;
      src_j_reg    <= src_j_next;
    end
  end

  assign h_input_enable_override_en = h_die_en_reg;
  assign j_input_enable_override_en = j_die_en_reg;
  assign change_source_h            = src_h_reg;
  assign change_source_j            = src_j_reg;

  // pull-up, direction and output value are never taken over, so the
  // normal port registers keep those pins; the forced input value is 0
  assign h_pullup_override_en     = `PHJ_RST_OVR;
  assign h_pullup_override_val    = `PHJ_RST_OVR;
  assign h_direction_override_en  = `PHJ_RST_OVR;
  assign h_direction_override_val = `PHJ_RST_OVR;
  assign h_outvalue_override_en   = `PHJ_RST_OVR;
  assign h_outvalue_override_val  = `PHJ_RST_OVR;
  assign h_toggle_override_en     = `PHJ_RST_OVR; // no toggle function
  assign h_input_enable_override_val = `PHJ_RST_OVR;
  assign j_pullup_override_en     = `PHJ_RST_OVR;
  assign j_pullup_override_val    = `PHJ_RST_OVR;
  assign j_direction_override_en  = `PHJ_RST_OVR;
  assign j_direction_override_val = `PHJ_RST_OVR;
  assign j_outvalue_override_en   = `PHJ_RST_OVR;
  assign j_outvalue_override_val  = `PHJ_RST_OVR;
  assign j_toggle_override_en     = `PHJ_RST_OVR; // no toggle function
  assign j_input_enable_override_val = `PHJ_RST_OVR;
endmodule

/* File: tb/phj_pin_override_properties.sv */
// checker for the port h/j pin override block: bus answers, fixed
// overrides, input-enable updates and pin routing delay.
// assumes it is bound to the top module and sees its ports only.
`timescale 1ns/10ps
module phj_pin_override_chk
  import phj_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic               wb_ack_o,
  input wire phj_pkg::phj_port_t pin_h_in,
  input wire phj_pkg::phj_jalt_t pin_j_in,
  input wire phj_pkg::phj_port_t h_pullup_override_en,
  input wire phj_pkg::phj_port_t h_pullup_override_val,
  input wire phj_pkg::phj_port_t h_direction_override_en,
  input wire phj_pkg::phj_port_t h_direction_override_val,
  input wire phj_pkg::phj_port_t h_outvalue_override_en,
  input wire phj_pkg::phj_port_t h_outvalue_override_val,
  input wire phj_pkg::phj_port_t h_toggle_override_en,
  input wire phj_pkg::phj_port_t h_input_enable_override_en,
  input wire phj_pkg::phj_port_t h_input_enable_override_val,
  input wire phj_pkg::phj_port_t j_pullup_override_en,
  input wire phj_pkg::phj_port_t j_pullup_override_val,
  input wire phj_pkg::phj_port_t j_direction_override_en,
  input wire phj_pkg::phj_port_t j_direction_override_val,
  input wire phj_pkg::phj_port_t j_outvalue_override_en,
  input wire phj_pkg::phj_port_t j_outvalue_override_val,
  input wire phj_pkg::phj_port_t j_toggle_override_en,
  input wire phj_pkg::phj_port_t j_input_enable_override_en,
  input wire phj_pkg::phj_port_t j_input_enable_override_val,
  input wire phj_pkg::phj_port_t change_source_h,
  input wire phj_pkg::phj_jalt_t change_source_j
);
  // --------------------------------------------------------------
  // fixed overrides gathered so one slip anywhere shows up
  // --------------------------------------------------------------
  phj_port_t h_fixed;  // any fixed port h override bit set
  phj_port_t j_fixed;  // same for port j, incl. bit 7 input enable
  assign h_fixed = h_pullup_override_en | h_pullup_override_val |
    h_direction_override_en | h_direction_override_val |
    h_outvalue_override_en | h_outvalue_override_val |
    h_toggle_override_en | h_input_enable_override_val;
  assign j_fixed = j_pullup_override_en | j_pullup_override_val |
    j_direction_override_en | j_direction_override_val |
    j_outvalue_override_en | j_outvalue_override_val |
    j_toggle_override_en | j_input_enable_override_val |
    {j_input_enable_override_en[7], 7'h00};
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_h_fixed_zero: assert property (h_fixed == 8'h00)
    else $error("port h fixed override not zero");
  a_j_fixed_zero: assert property (j_fixed == 8'h00)
    else $error("port j fixed override not zero");
  // enables only move on the edge after an acked write
  a_ie_after_write: assert property (!$stable(h_input_enable_override_en)
    || !$stable(j_input_enable_override_en) |->
    $past(wb_ack_o && wb_we_i))
    else $error("input enable changed without a write");
  // the two sync stages and the source register need three clean edges before the check holds
  a_h_route_delay: assert property (!$past(rst, 1) && !$past(rst, 2) &&
    !$past(rst, 3) |-> change_source_h == $past(pin_h_in, 3))
    else $error("port h change source mismatch");
  a_j_route_delay: assert property (!$past(rst, 1) && !$past(rst, 2) &&
    !$past(rst, 3) |-> change_source_j == $past(pin_j_in, 3))
    else $error("port j change source mismatch");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("request not answered next cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
endmodule

/* File: tb/phj_pin_override_tb.sv */
// testbench for the port h/j pin override block: registers, gated
// input enables and pin routing to the change sources.
// assumes the package, header and checker are compiled before it.
`timescale 1ns/10ps
`include "phj_consts.svh"
module phj_pin_override_tb;
  import phj_pkg::*;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic       ref_clk;
  logic       rst;
  logic       wb_cyc_i;
  logic       wb_stb_i;
  logic       wb_we_i;
  phj_addr_t  wb_adr_i;
  logic [3:0] wb_sel_i;
  phj_word_t  wb_dat_i;
  phj_word_t  wb_dat_o;
  logic       wb_ack_o;
  phj_port_t  pin_h_in;
  phj_jalt_t  pin_j_in;
  phj_port_t  h_ie;            // input-enable override enables, port h
  phj_port_t  j_ie;            // same for port j
  phj_port_t  change_source_h;
  phj_jalt_t  change_source_j;
  phj_word_t  rdat;            // read data taken at the acked edge
  phj_port_t  v;               // pattern under test
  phj_jalt_t  u;               // port j pattern under test
  phj_port_t  pats [4];        // mask patterns, incl. all ones
  int         n_errors;
  int         checks;
  phj_pin_override i_phj_pin_override (
    .ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_h_in, .pin_j_in,
    .h_pullup_override_en(), .h_pullup_override_val(),
    .h_direction_override_en(), .h_direction_override_val(),
    .h_outvalue_override_en(), .h_outvalue_override_val(),
    .h_toggle_override_en(), .h_input_enable_override_en(h_ie),
    .h_input_enable_override_val(), .j_pullup_override_en(),
    .j_pullup_override_val(), .j_direction_override_en(),
    .j_direction_override_val(), .j_outvalue_override_en(),
    .j_outvalue_override_val(), .j_toggle_override_en(),
    .j_input_enable_override_en(j_ie), .j_input_enable_override_val(),
    .change_source_h, .change_source_j);
  // --------------------------------------------------------------
  // clock, bus and check tasks
  // --------------------------------------------------------------
  always #20 ref_clk = ~ref_clk;
  // one classic cycle: the request stands until ack is seen high at a
  // rising edge, read data is taken at that edge, then it is released;
  // the wait is bounded so a dead slave cannot hang the bench
  task automatic bus(input phj_addr_t a, input logic w,
                     input logic [3:0] s, input phj_word_t d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      $display("BAD %0t bus answer missing", $time);
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic check(input phj_word_t got, input phj_word_t exp,
                       input string msg);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    pin_h_in = 8'h00;
    pin_j_in = 7'h00;
    pats = '{8'h00, 8'hff, 8'h5a, 8'h81};
    n_errors = 0;
    checks = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i += 4) begin
      bus(4'(i), 1'b0, 4'h1, 32'h0);
      check(rdat, 32'h0, "reset value");
    end
    $display("reset test done");
    // masks stay off the pins until the group enable is set
    bus(`PHJ_OFS_MASK_H, 1'b1, 4'h1, 32'h0000_00a5);
    bus(`PHJ_OFS_MASK_J, 1'b1, 4'h1, 32'hffff_ffff);
    @(negedge ref_clk);
    check({16'h0, h_ie, j_ie}, 32'h0, "gated enable");
    bus(`PHJ_OFS_CTRL, 1'b1, 4'h1, 32'h1);
    @(negedge ref_clk);
    check({16'h0, h_ie, j_ie}, 32'ha57f, "enabled");
    bus(`PHJ_OFS_CTRL, 1'b0, 4'h1, 32'h0);
    check(rdat, 32'h1, "ctrl readback");
    foreach (pats[k]) begin
      v = pats[k];
      bus(`PHJ_OFS_MASK_H, 1'b1, 4'h1, {24'h0, v});
      bus(`PHJ_OFS_MASK_J, 1'b1, 4'h1, {24'h0, v});
      @(negedge ref_clk);
      check({16'h0, h_ie, j_ie}, {16'h0, v, 1'b0, v[6:0]}, "mask");
      bus(`PHJ_OFS_MASK_J, 1'b0, 4'h1, 32'h0);
      check(rdat, {25'h0, v[6:0]}, "mask j readback");
    end
    bus(`PHJ_OFS_CTRL, 1'b1, 4'h1, 32'h0);
    @(negedge ref_clk);
    check({16'h0, h_ie, j_ie}, 32'h0, "group off");
    $display("enable test done");
    // refused writes: lane 0 off, unmapped place, read-only status
    bus(`PHJ_OFS_MASK_H, 1'b1, 4'he, 32'h0000_0033);
    bus(4'h1, 1'b1, 4'h1, 32'h0000_00ff);
    bus(`PHJ_OFS_STATUS, 1'b1, 4'h1, 32'h0000_7fff);
    bus(4'h1, 1'b0, 4'h1, 32'h0);
    check(rdat, 32'h0, "unmapped read");
    bus(`PHJ_OFS_MASK_H, 1'b0, 4'h1, 32'h0);
    check(rdat, 32'h81, "mask h kept");
    $display("refusal test done");
    // a reset in mid-run clears masks and enables at once
    bus(`PHJ_OFS_CTRL, 1'b1, 4'h1, 32'h1);
    @(negedge ref_clk);
    check({16'h0, h_ie, j_ie}, 32'h8101, "enable again");
    @(posedge ref_clk);
    rst <= 1'b1;
    @(negedge ref_clk);
    check({16'h0, h_ie, j_ie}, 32'h0, "enable in reset");
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    bus(`PHJ_OFS_MASK_H, 1'b0, 4'h1, 32'h0);
    check(rdat, 32'h0, "mask h after reset");
    $display("mid reset test done");
    for (int i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      u = ~(7'h01 << i);
      @(posedge ref_clk);
      pin_h_in <= v;
      pin_j_in <= u;
      repeat (4) @(negedge ref_clk);
      check({change_source_h, change_source_j}, {v, u}, "route");
      bus(`PHJ_OFS_STATUS, 1'b0, 4'h1, 32'h0);
      check(rdat, {17'h0, u, v}, "status");
    end
    $display("routing test done");
    wrap_up();
  end
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #(40 * 4000);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
bind phj_pin_override phj_pin_override_chk i_chk (
  .ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .pin_h_in,
  .pin_j_in, .h_pullup_override_en, .h_pullup_override_val,
  .h_direction_override_en, .h_direction_override_val,
  .h_outvalue_override_en, .h_outvalue_override_val,
  .h_toggle_override_en, .h_input_enable_override_en,
  .h_input_enable_override_val, .j_pullup_override_en,
  .j_pullup_override_val, .j_direction_override_en,
  .j_direction_override_val, .j_outvalue_override_en,
  .j_outvalue_override_val, .j_toggle_override_en,
  .j_input_enable_override_en, .j_input_enable_override_val,
  .change_source_h, .change_source_j);
